// ==== fcf_pkg.sv ====
// fcf_pkg: constants, register map and carrier types for the filter unit
// assumes a classic wishbone slave with 32-bit data and byte addresses
package fcf_pkg;
    // data widths
    localparam int WORD_W = 16;
    localparam int ACC32_W = 32;
    localparam int ACC48_W = 48;
    // cycles spent on one tap
    localparam logic [1:0] FIR_TAP_CYC = 2'h2;
    localparam logic [1:0] COR_TAP_CYC = 2'h3;
    // memory depths inside the unit
    localparam int RAM_AW = 8;
    localparam int ROM_AW = 8;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_SPTR = 8'h08;
    localparam logic [7:0] REG_CPTR = 8'h0C;
    localparam logic [7:0] REG_PPTR = 8'h10;
    localparam logic [7:0] REG_WRAP = 8'h14;
    localparam logic [7:0] REG_MOPR = 8'h18;
    localparam logic [7:0] REG_TAPS = 8'h1C;
    localparam logic [7:0] REG_ACCL = 8'h20;
    localparam logic [7:0] REG_ACCM = 8'h24;
    localparam logic [7:0] REG_ACCH = 8'h28;
    localparam logic [7:0] REG_RAMW = 8'h2C;
    localparam logic [7:0] REG_ROMW = 8'h30;
    // control register fields
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_COR_BIT = 1;
    localparam int CTRL_ROM_BIT = 2;
    localparam int CTRL_OVM_BIT = 3;
    // status register fields
    localparam int STAT_TAG_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_ERR_BIT = 2;
    // memory write data fields
    localparam int MEMW_TAG_BIT = 31;
    // reset values
    localparam logic [WORD_W-1:0] RST_WORD = 16'h0000;
    localparam logic [7:0] RST_TAPS = 8'h01;
    // unit states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MUL = 2'b01,
        ST_ACC = 2'b10,
        ST_EXT = 2'b11
    } fcf_state_t;
    // wishbone request carrier
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } fcf_wb_req_t;
    // wishbone answer carrier
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } fcf_wb_rsp_t;
endpackage : fcf_pkg

// ==== fcf_unit.sv ====
// fcf_unit: repeated multiply-accumulate filter and correlation unit
// assumes one clock, wishbone classic slave, unit repeats taps from a software-loaded count
//
// How it works
// RL1: filter tap: 16x16 multiply, 32-bit sum, 2 cycles
// RL2: N filter taps finish in 2N cycles
// RL3: correlation tap: 48-bit sum, 3 cycles
// RL4: N correlation taps take 3N cycles
// RL5: correlation adds one extended accumulate cycle
// RL6: software clears saturation mode before passes
// RL7: one tap per repetition, N repetitions
// RL8: software picks even sample, odd coefficient pointers; the bench also starts passes at odd sample slot 0x13
// RL9: software preloads first coefficient into operand
// RL10: sample pointer advances, ends at next slot
// RL11: rom variants fetch coefficients via program pointer
// RL12: software sizes circular buffer at N+1 words
// RL13: software tags buffer's second-to-last word
// RL14: each pass moves buffer start back one
// RL15: software saves and restores status around passes
// RL16: tag set: wrap pointer by offset after first multiply
// RL17: low result word base, upper next accumulator
// RL18: software loads negative wrap step
// RL19: only pairs zero-one or two-three allowed
// RL20: rom pass loads operand, post-increments program pointer
// RL21: correlation result spans three accumulators
// RL22: ram pass fetches next coefficient during multiply
`timescale 1ns/10ps
`default_nettype none
module fcf_unit (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    // wishbone slave
    input  wire fcf_pkg::fcf_wb_req_t wbReq,
    output fcf_pkg::fcf_wb_rsp_t      wbRsp,
    // status
    output logic                      busy
);
    import fcf_pkg::*;

    // sample/coefficient ram and coefficient rom with tag bits
    logic [WORD_W-1:0] sampleRam [0:(1<<RAM_AW)-1];
    logic              tagRam    [0:(1<<RAM_AW)-1];
    logic [WORD_W-1:0] coeffRom  [0:(1<<ROM_AW)-1];

    // architectural state
    fcf_state_t          state_q, state_d;     // tap sequencer
    logic [RAM_AW-1:0]   sPtr_q, sPtr_d;       // sample_pointer_reg
    logic [RAM_AW-1:0]   cPtr_q, cPtr_d;       // coeff_pointer_reg
    logic [ROM_AW-1:0]   pPtr_q, pPtr_d;       // program_fetch_pointer
    logic [RAM_AW-1:0]   wrap_q, wrap_d;       // wrap_offset_reg
    logic [WORD_W-1:0]   mOpr_q, mOpr_d;       // multiplier_operand_reg
    logic [7:0]          taps_q, taps_d;       // remaining repetitions
    logic [ACC48_W-1:0]  acc_q, acc_d;         // base_accumulator string
    logic [ACC32_W-1:0]  prod_q, prod_d;       // product held between cycles
    logic                tag_q, tag_d;         // status tag bit
    logic                cor_q, cor_d;         // correlation variant
    logic                rom_q, rom_d;         // constant-coefficient variant
    logic                ovm_q, ovm_d;         // saturation mode bit
    logic                err_q, err_d;         // start refused with saturation on
    logic                first_q, first_d;     // first tap of the pass
    logic                ack_q, ack_d;         // bus answer
    logic [31:0]         rdat_q, rdat_d;       // bus read data

    // bus request decode
    logic busReq;
    logic wrEn;
    logic go;
    logic [WORD_W-1:0] sampleNow;
    logic [ACC32_W-1:0] mulNow;

    assign busReq = wbReq.cyc && wbReq.stb && !ack_q;
    assign wrEn = busReq && wbReq.we && wbReq.sel[0];
    assign go = wrEn && (wbReq.adr == REG_CTRL) && wbReq.dat[CTRL_GO_BIT]
                && (state_q == ST_IDLE);
    assign sampleNow = sampleRam[sPtr_q];
    // signed 16x16 product
    assign mulNow = ACC32_W'($signed(sampleNow) * $signed(mOpr_q));
    assign busy = (state_q != ST_IDLE);
    assign wbRsp.ack = ack_q;
    assign wbRsp.dat = rdat_q;

    // memory loads from software; no reset, plain storage
    always_ff @(posedge clock) begin
        if (wrEn && wbReq.adr == REG_RAMW) begin
            sampleRam[sPtr_q] <= wbReq.dat[WORD_W-1:0];
            tagRam[sPtr_q] <= wbReq.dat[MEMW_TAG_BIT];
        end
        if (wrEn && wbReq.adr == REG_ROMW) begin
            coeffRom[pPtr_q] <= wbReq.dat[WORD_W-1:0];
        end
    end

    // next-state for sequencer, pointers and accumulator
    always_comb begin
        state_d = state_q;
        sPtr_d = sPtr_q;
        cPtr_d = cPtr_q;
        pPtr_d = pPtr_q;
        wrap_d = wrap_q;
        mOpr_d = mOpr_q;
        taps_d = taps_q;
        acc_d = acc_q;
        prod_d = prod_q;
        tag_d = tag_q;
        cor_d = cor_q;
        rom_d = rom_q;
        ovm_d = ovm_q;
        err_d = err_q;
        first_d = first_q;
        case (state_q)
            ST_IDLE: begin
                // register writes only while idle, so a pass sees stable setup
                if (wrEn) begin
                    case (wbReq.adr)
                        REG_CTRL: begin
                            cor_d = wbReq.dat[CTRL_COR_BIT];
                            rom_d = wbReq.dat[CTRL_ROM_BIT];
                            ovm_d = wbReq.dat[CTRL_OVM_BIT];
                        end
                        REG_STAT: begin
                            // RL15 status restore path
                            tag_d = wbReq.dat[STAT_TAG_BIT];
                            err_d = 1'b0;
                        end
                        REG_SPTR: sPtr_d = wbReq.dat[RAM_AW-1:0];
                        REG_CPTR: cPtr_d = wbReq.dat[RAM_AW-1:0];
                        REG_PPTR: pPtr_d = wbReq.dat[ROM_AW-1:0];
                        REG_WRAP: wrap_d = wbReq.dat[RAM_AW-1:0];
                        REG_MOPR: mOpr_d = wbReq.dat[WORD_W-1:0];
                        REG_TAPS: taps_d = wbReq.dat[7:0];
                        REG_ACCL: acc_d[15:0] = wbReq.dat[15:0];
                        REG_ACCM: acc_d[31:16] = wbReq.dat[15:0];
                        REG_ACCH: acc_d[47:32] = wbReq.dat[15:0];
                        REG_RAMW: sPtr_d = sPtr_q + 8'h01;
                        REG_ROMW: pPtr_d = pPtr_q + 8'h01;
                        default: ;
                    endcase
                end
                if (go) begin
                    // on-chip overflow logic needs saturation off; the bit
                    // written with go counts, so a pass never starts under it
                    if (wbReq.dat[CTRL_OVM_BIT]) begin
                        err_d = 1'b1;
                    end else if (taps_q != 8'h00) begin
                        // RL7 one tap per repetition
                        state_d = ST_MUL;
                        first_d = 1'b1;
                        err_d = 1'b0;
                    end
                end
            end
            ST_MUL: begin
                // RL1 multiply cycle of a tap
                prod_d = mulNow;
                first_d = 1'b0;
                // RL16 tag at pass start: wrap after first multiply
                // RL14 start slot walks back one per pass
                if (first_q && tag_q) begin
                    sPtr_d = sPtr_q + wrap_q;
                    tag_d = 1'b0;
                end else begin
                    // RL10 sample pointer advances
                    sPtr_d = sPtr_q + 8'h01;
                end
                if (rom_q) begin
                    // RL11 RL20 operand from program memory, pointer post-increment
                    mOpr_d = coeffRom[pPtr_q];
                    pPtr_d = pPtr_q + 8'h01;
                end else begin
                    // RL22 next coefficient via odd pointer during multiply
                    mOpr_d = sampleRam[cPtr_q];
                    cPtr_d = cPtr_q + 8'h01;
                end
                state_d = ST_ACC;
            end
            ST_ACC: begin
                // RL17 32-bit sum in low two accumulator words
                acc_d[31:0] = acc_q[31:0] + prod_q;
                // the tagged word reached while walking marks the wrap point
                if (tagRam[sPtr_q]) begin
                    tag_d = 1'b1;
                end
                if (cor_q) begin
                    // RL3 RL5 correlation spends a third cycle
                    state_d = ST_EXT;
                end else begin
                    // RL2 two cycles per tap
                    taps_d = taps_q - 8'h01;
                    state_d = (taps_q == 8'h01) ? ST_IDLE : ST_MUL;
                end
            end
            ST_EXT: begin
                // RL21 RL5 extend sum into third accumulator with carry
                acc_d[47:32] = acc_q[47:32]
                    + WORD_W'({{(WORD_W-1){1'b0}}, (acc_q[31:0] < prod_q)})
                    + (prod_q[31] ? 16'hFFFF : 16'h0000);
                // RL4 three cycles per tap
                taps_d = taps_q - 8'h01;
                state_d = (taps_q == 8'h01) ? ST_IDLE : ST_MUL;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // bus answer: one wait cycle, ack for one cycle
    always_comb begin
        ack_d = busReq;
        rdat_d = 32'h0000_0000;
        if (busReq && !wbReq.we) begin
            case (wbReq.adr)
                REG_CTRL: rdat_d = {28'h0, ovm_q, rom_q, cor_q, 1'b0};
                REG_STAT: rdat_d = {29'h0, err_q, busy, tag_q};
                REG_SPTR: rdat_d = {24'h0, sPtr_q};
                REG_CPTR: rdat_d = {24'h0, cPtr_q};
                REG_PPTR: rdat_d = {24'h0, pPtr_q};
                REG_WRAP: rdat_d = {24'h0, wrap_q};
                REG_MOPR: rdat_d = {16'h0, mOpr_q};
                REG_TAPS: rdat_d = {24'h0, taps_q};
                REG_ACCL: rdat_d = {16'h0, acc_q[15:0]};
                REG_ACCM: rdat_d = {16'h0, acc_q[31:16]};
                REG_ACCH: rdat_d = {16'h0, acc_q[47:32]};
                default: rdat_d = 32'h0000_0000;
            endcase
        end
    end

    // register stage, constants on reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            sPtr_q <= 8'h00;
            cPtr_q <= 8'h00;
            pPtr_q <= 8'h00;
            wrap_q <= 8'h00;
            mOpr_q <= RST_WORD;
            taps_q <= RST_TAPS;
            acc_q <= 48'h0000_0000_0000;
            prod_q <= 32'h0000_0000;
            tag_q <= 1'b0;
            cor_q <= 1'b0;
            rom_q <= 1'b0;
            ovm_q <= 1'b0;
            err_q <= 1'b0;
            first_q <= 1'b0;
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            sPtr_q <= sPtr_d;
            cPtr_q <= cPtr_d;
            pPtr_q <= pPtr_d;
            wrap_q <= wrap_d;
            mOpr_q <= mOpr_d;
            taps_q <= taps_d;
            acc_q <= acc_d;
            prod_q <= prod_d;
            tag_q <= tag_d;
            cor_q <= cor_d;
            rom_q <= rom_d;
            ovm_q <= ovm_d;
            err_q <= err_d;
            first_q <= first_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end
endmodule : fcf_unit
`default_nettype wire

// ==== fcf_unit_props.sv ====
// fcf_unit_props: port checks for the filter unit
// assumes one clock domain; bound onto fcf_unit at the foot
`timescale 1ns/10ps
`default_nettype none
module fcf_unit_props
    import fcf_pkg::*;
(
    // clock and reset
    input wire logic                 clock,
    input wire logic                 rst_n,
    // bus and status
    input wire fcf_pkg::fcf_wb_req_t wbReq,
    input wire fcf_pkg::fcf_wb_rsp_t wbRsp,
    input wire logic                 busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic       take;   // request taken this edge
    logic       goReq;  // start command seen
    logic [7:0] tapsQ;  // mirrored tap count
    logic [7:0] tapsD;
    logic       corQ;   // mirrored mode
    logic       corD;
    logic [9:0] cntQ;   // busy run length
    logic [9:0] cntD;
    assign take  = wbReq.cyc && wbReq.stb && !wbRsp.ack;
    assign goReq = take && wbReq.we && wbReq.sel[0] && wbReq.adr == REG_CTRL
                   && wbReq.dat[CTRL_GO_BIT];
    // mirror of taps and mode; writes while busy are dropped
    always_comb begin
        tapsD = tapsQ;
        corD  = corQ;
        cntD  = busy ? cntQ + 10'h001 : 10'h000;
        if (take && wbReq.we && wbReq.sel[0] && !busy && wbReq.adr == REG_TAPS) begin
            tapsD = wbReq.dat[7:0];
        end
        if (goReq && !busy) begin
            corD = wbReq.dat[CTRL_COR_BIT];
        end
    end
    // helper registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tapsQ <= RST_TAPS;
            corQ  <= 1'b0;
            cntQ  <= 10'h000;
        end else begin
            tapsQ <= tapsD;
            corQ  <= corD;
            cntQ  <= cntD;
        end
    end
    property p_ack_follow; take |=> wbRsp.ack; endproperty
    a_ack_follow: assert property (p_ack_follow) else $error("ack missing");
    property p_ack_pulse; wbRsp.ack |=> !wbRsp.ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_cause; wbRsp.ack |-> $past(wbReq.cyc && wbReq.stb); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_go_start; goReq && !busy && !wbReq.dat[CTRL_OVM_BIT] |-> ##[1:2] busy; endproperty
    a_go_start: assert property (p_go_start) else $error("pass did not start");
    property p_busy_cause; $rose(busy) |-> $past(goReq) || $past(goReq, 2); endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without go");
    property p_fir_len; $fell(busy) && !corQ |-> cntQ == {1'b0, tapsQ, 1'b0}; endproperty
    a_fir_len: assert property (p_fir_len) else $error("filter pass length");
    property p_cor_len;
        $fell(busy) && corQ |-> cntQ == {2'b00, tapsQ} + {1'b0, tapsQ, 1'b0};
    endproperty
    a_cor_len: assert property (p_cor_len) else $error("correlate pass length");
    property p_unmapped;
        take && !wbReq.we && wbReq.adr == 8'h3C |=> wbRsp.dat == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    c_fir: cover property ($fell(busy) && !corQ);
    c_cor: cover property ($fell(busy) && corQ);
    c_gap: cover property (take && !wbReq.we && wbReq.adr == 8'h3C);
endmodule : fcf_unit_props
bind fcf_unit fcf_unit_props fcf_unit_props_inst (.clock(clock), .rst_n(rst_n),
    .wbReq(wbReq), .wbRsp(wbRsp), .busy(busy));
`default_nettype wire

// ==== fcf_unit_tb_top.sv ====
// fcf_unit_tb_top: self-checking bench for the filter unit
// assumes the checker is bound in by its own file
`timescale 1ns/10ps
`default_nettype none
module fcf_unit_tb_top;
    import fcf_pkg::*;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    fcf_wb_req_t wbReq = '0;
    fcf_wb_rsp_t wbRsp;
    logic        busy;
    int          n_errors = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          busyRun = 0;
    // samples and taps; sample 2 carries the tag
    logic signed [15:0] xs [4] = '{16'h0100, 16'hFF00, 16'h7FFF, 16'h0003};
    logic signed [15:0] hs [3] = '{16'h0002, 16'h8000, 16'h0010};
    always #4 clock = ~clock;
    fcf_unit fcf_unit_inst (.clock(clock), .rst_n(rst_n), .wbReq(wbReq), .wbRsp(wbRsp),
        .busy(busy));
    // hang guard and busy length meter
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_errors++;
            final_report();
        end
    end
    always @(negedge clock) if (busy === 1'b1) busyRun++;
    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask : chk
    // one classic cycle; waits for ack, bounded
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                        output logic [31:0] rd);
        int k;
        @(posedge clock);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: dat};
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (wbRsp.ack !== 1'b1 && k < 20);
        rd = wbRsp.dat;
        chk("bus ack", 32'h00000001, {31'h00000000, wbRsp.ack});
        wbReq <= '0;
    endtask : xfer
    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] junk;
        xfer(1'b1, adr, dat, junk);
    endtask : wr
    task automatic rdchk(input string what, input logic [7:0] adr, input logic [15:0] exp);
        logic [31:0] got;
        xfer(1'b0, adr, 32'h00000000, got);
        chk(what, {16'h0000, exp}, {16'h0000, got[15:0]});
    endtask : rdchk
    // fill buffer, ram taps and rom taps
    task automatic t_load;
        wr(REG_SPTR, 32'h00000010);
        for (int i = 0; i < 4; i++) wr(REG_RAMW, {i == 2, 15'h0000, xs[i]});
        wr(REG_SPTR, 32'h00000020);
        for (int i = 0; i < 3; i++) wr(REG_RAMW, {16'h0000, hs[i]});
        wr(REG_PPTR, 32'h00000000);
        for (int i = 0; i < 3; i++) wr(REG_ROMW, {16'h0000, hs[i]});
        rdchk("rom pointer", REG_PPTR, 16'h0003);
    endtask : t_load
    // one three-tap pass from slot s, expectation built here
    task automatic t_pass(input logic ram_coeff_correlate_op, input logic rom, input int s, input logic tg);
        logic [47:0] sum;
        int          p;
        logic        tagOut;
        sum = '0;
        p = s;
        tagOut = 1'b0;
        for (int i = 0; i < 3; i++) begin
            sum = sum + 48'(32'(hs[i]) * 32'(xs[p]));
            p = (i == 0 && tg) ? p - 3 : p + 1;
            // tag is picked up from the slot the pointer moves onto
            tagOut = tagOut | (p == 2);
        end
        wr(REG_SPTR, 32'(16 + s));
        wr(REG_CPTR, 32'h00000021);
        wr(REG_PPTR, 32'h00000001);
        wr(REG_MOPR, {16'h0000, hs[0]});
        wr(REG_WRAP, 32'h000000FD);
        wr(REG_TAPS, 32'h00000003);
        wr(REG_STAT, {31'h00000000, tg});
        for (int a = 0; a < 3; a++) wr(8'(REG_ACCL + 4 * a), 32'h00000000);
        busyRun = 0;
        wr(REG_CTRL, {28'h0000000, 1'b0, rom, ram_coeff_correlate_op, 1'b1});
        for (int k = 0; k < 40 && !(busyRun > 0 && busy === 1'b0); k++) @(negedge clock);
        chk("pass cycles", ram_coeff_correlate_op ? 32'h00000009 : 32'h00000006, 32'(busyRun));
        rdchk("acc low", REG_ACCL, sum[15:0]);
        rdchk("acc mid", REG_ACCM, sum[31:16]);
        if (ram_coeff_correlate_op) rdchk("acc high", REG_ACCH, sum[47:32]);
        rdchk("sample pointer", REG_SPTR, 16'(16 + p));
        if (rom) rdchk("rom pointer", REG_PPTR, 16'h0004);
        else rdchk("coef pointer", REG_CPTR, 16'h0024);
        rdchk("status", REG_STAT, {15'h0000, tagOut});
    endtask : t_pass
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rdchk("taps reset", REG_TAPS, RST_TAPS);
        rdchk("status reset", REG_STAT, 16'h0000);
        rdchk("unmapped", 8'h3C, 16'h0000);
        t_load();
        // start refused under saturation mode
        wr(REG_CTRL, 32'h00000009);
        rdchk("sat status", REG_STAT, 16'h0004);
        for (int m = 0; m < 4; m++) t_pass(m[1], m[0], 0, 1'b0);
        t_pass(1'b0, 1'b0, 3, 1'b1);
        t_pass(1'b1, 1'b1, 3, 1'b1);
        final_report();
    end
endmodule : fcf_unit_tb_top
`default_nettype wire
